// ===== src/data_space_pkg.sv
// constants and types for the data-space decoder
package data_space_pkg;
    // ==========================================
    // data space map
    localparam logic [15:0] REGFILE_BASE  = 16'h0000;
    localparam logic [15:0] STDIO_BASE    = 16'h0020;
    localparam logic [15:0] EXTIO_BASE    = 16'h0060;
    localparam logic [15:0] SRAM_BASE_NRM = 16'h0100;
    localparam logic [15:0] SRAM_BASE_CMP = 16'h0060;
    localparam logic [15:0] SRAM_SIZE_NRM = 16'h1000;
    localparam logic [15:0] SRAM_SIZE_CMP = 16'h0FA0;
    localparam logic [15:0] SRAM_END_NRM  = SRAM_BASE_NRM + SRAM_SIZE_NRM;
    localparam logic [15:0] SRAM_END_CMP  = SRAM_BASE_CMP + SRAM_SIZE_CMP;
    localparam logic [15:0] PORT_IO_OFS   = 16'h0020;

    // ==========================================
    // stall cycles of external accesses
    localparam logic [3:0] EXT_BYTE_NOWAIT = 4'h1;
    localparam logic [3:0] EXT_PAIR_BASE   = 4'h3;

    // ==========================================
    // types
    typedef enum logic [2:0] {
        REGION_REGFILE,
        REGION_STDIO,
        REGION_EXTIO,
        REGION_SRAM,
        REGION_EXT
    } region_t;

    typedef enum logic [2:0] {
        AMODE_DIRECT,
        AMODE_DISP,
        AMODE_INDIRECT,
        AMODE_PREDEC,
        AMODE_POSTINC
    } amode_t;

    typedef enum logic [1:0] {
        PTR_X,
        PTR_Y,
        PTR_Z
    } ptr_t;
endpackage

// ===== src/data_space_decoder.sv
// data-space address generation, region decode and access sequencing
// ==========================================
// Overview of operation
// - normal map: 32 regfile, 64 std I/O, 160 ext I/O, 4096 SRAM.
// - compat map: 32 regfile, 64 std I/O, 4000 SRAM, no ext I/O.
// - ext I/O 0x60-0xFF only by load/store, never port ops; gone in compat.
// - addresses above internal data go to external SRAM, same instructions.
// - internal accesses keep external read and write strobes inactive.
// - external SRAM used only while the external memory enable bit is set.
// - zero-wait external byte access costs one cycle more than internal.
// - zero-wait external stack: call, return, interrupt take three extra cycles.
// - one/two/three wait states add two/three/four cycles per external byte.
// - external stack with 1/2/3 wait states adds five/seven/nine cycles.
// - internal SRAM access takes two cycles: address, then data phase.
// - displacement mode adds unsigned displacement up to 63 to pointer.
// - pointers X,Y,Z from R26-R31; pre-decrement before, post-increment after.
// - direct addressing reaches the whole 64K data space.
// - port instruction I/O offsets 0-0x3F appear at offset plus 0x20.
module data_space_decoder (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    input  wire logic                     compat_mode_i,
    input  wire logic                     ext_mem_enable_bit_i,
    input  wire logic [1:0]               wait_states_i,
    input  wire logic                     req_i,
    input  wire logic                     we_i,
    input  wire logic                     pc_pair_i,
    input  wire logic                     port_op_i,
    input  wire logic [5:0]               port_addr_i,
    input  wire data_space_pkg::amode_t   amode_i,
    input  wire data_space_pkg::ptr_t     ptr_sel_i,
    input  wire logic [15:0]              direct_addr_i,
    input  wire logic [5:0]               disp_i,
    input  wire logic [15:0]              ptr_x_i,
    input  wire logic [15:0]              ptr_y_i,
    input  wire logic [15:0]              ptr_z_i,
    input  wire logic [7:0]               wdata_i,
    input  wire logic [7:0]               regfile_rdata_i,
    input  wire logic [7:0]               stdio_rdata_i,
    input  wire logic [7:0]               extio_rdata_i,
    input  wire logic [7:0]               sram_rdata_i,
    input  wire logic [7:0]               ext_rdata_i,
    output logic                          ready_o,
    output logic                          done_o,
    output logic [7:0]                    rdata_o,
    output logic [15:0]                   addr_o,
    output logic [15:0]                   local_addr_o,
    output data_space_pkg::region_t       region_o,
    output logic                          addr_valid_o,
    output logic                          int_rd_o,
    output logic                          int_wr_o,
    output logic [7:0]                    wdata_o,
    output logic                          ext_rd_n_o,
    output logic                          ext_wr_n_o,
    output logic                          ptr_wr_o,
    output data_space_pkg::ptr_t          ptr_wr_sel_o,
    output logic [15:0]                   ptr_wr_val_o
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA
    } state_t;

    // ==========================================
    // state
    state_t                  st_q,      st_d;
    logic [15:0]             addr_q,    addr_d;
    logic [15:0]             loc_q,     loc_d;
    data_space_pkg::region_t reg_q,     reg_d;
    logic                    we_q,      we_d;
    logic                    ext_on_q,  ext_on_d;
    logic [3:0]              cnt_q,     cnt_d;
    logic [7:0]              wdat_q,    wdat_d;
    logic [7:0]              rdat_q,    rdat_d;
    logic                    pwr_q,     pwr_d;
    data_space_pkg::ptr_t    psel_q,    psel_d;
    logic [15:0]             pval_q,    pval_d;

    logic                    accept;
    logic [15:0]             base;
    logic [15:0]             eff;
    logic [15:0]             sram_base;
    logic [15:0]             sram_end;
    data_space_pkg::region_t rgn;
    logic [15:0]             loc;
    logic [3:0]              extra;
    logic [7:0]              rmux;

    assign accept = (st_q == ST_IDLE) && req_i;

    // ==========================================
    // address generation
    always_comb begin
        case (ptr_sel_i)
            data_space_pkg::PTR_X: base = ptr_x_i;
            data_space_pkg::PTR_Y: base = ptr_y_i;
            default:               base = ptr_z_i;
        endcase
        if (port_op_i) begin
            eff = {10'h000, port_addr_i} + data_space_pkg::PORT_IO_OFS;
        end else begin
            case (amode_i)
                data_space_pkg::AMODE_DIRECT:  eff = direct_addr_i;
                data_space_pkg::AMODE_DISP:    eff = base + {10'h000, disp_i};
                data_space_pkg::AMODE_PREDEC:  eff = base - 16'h0001;
                default:                       eff = base;
            endcase
        end
    end

    // ==========================================
    // region decode
    always_comb begin
        sram_base = compat_mode_i ? data_space_pkg::SRAM_BASE_CMP
                                  : data_space_pkg::SRAM_BASE_NRM;
        sram_end  = compat_mode_i ? data_space_pkg::SRAM_END_CMP
                                  : data_space_pkg::SRAM_END_NRM;
        if (eff < data_space_pkg::STDIO_BASE) begin
            rgn = data_space_pkg::REGION_REGFILE;
            loc = eff - data_space_pkg::REGFILE_BASE;
        end else if (eff < data_space_pkg::EXTIO_BASE) begin
            rgn = data_space_pkg::REGION_STDIO;
            loc = eff - data_space_pkg::STDIO_BASE;
        end else if (eff < sram_base) begin
            rgn = data_space_pkg::REGION_EXTIO;
            loc = eff - data_space_pkg::EXTIO_BASE;
        end else if (eff < sram_end) begin
            rgn = data_space_pkg::REGION_SRAM;
            loc = eff - sram_base;
        end else begin
            rgn = data_space_pkg::REGION_EXT;
            loc = eff - sram_end;
        end
        if (pc_pair_i) begin
            extra = data_space_pkg::EXT_PAIR_BASE
                  + {1'b0, wait_states_i, 1'b0};
        end else if (wait_states_i == 2'b00) begin
            extra = data_space_pkg::EXT_BYTE_NOWAIT;
        end else begin
            extra = {2'b00, wait_states_i} + 4'h1;
        end
    end

    // ==========================================
    // read data select
    always_comb begin
        case (reg_q)
            data_space_pkg::REGION_REGFILE: rmux = regfile_rdata_i;
            data_space_pkg::REGION_STDIO:   rmux = stdio_rdata_i;
            data_space_pkg::REGION_EXTIO:   rmux = extio_rdata_i;
            data_space_pkg::REGION_SRAM:    rmux = sram_rdata_i;
            default:                        rmux = ext_on_q ? ext_rdata_i : 8'h00;
        endcase
    end

    // ==========================================
    // access sequencer
    always_comb begin
        st_d     = st_q;
        addr_d   = addr_q;
        loc_d    = loc_q;
        reg_d    = reg_q;
        we_d     = we_q;
        ext_on_d = ext_on_q;
        cnt_d    = cnt_q;
        wdat_d   = wdat_q;
        rdat_d   = rdat_q;
        pwr_d    = 1'b0;
        psel_d   = psel_q;
        pval_d   = pval_q;
        case (st_q)
            ST_IDLE: begin
                if (req_i) begin
                    st_d     = ST_ADDR;
                    addr_d   = eff;
                    loc_d    = loc;
                    reg_d    = rgn;
                    we_d     = we_i;
                    wdat_d   = wdata_i;
                    ext_on_d = (rgn == data_space_pkg::REGION_EXT)
                            && ext_mem_enable_bit_i;
                    cnt_d    = ext_on_d ? extra : 4'h0;
                    if (!port_op_i && (amode_i == data_space_pkg::AMODE_PREDEC ||
                                       amode_i == data_space_pkg::AMODE_POSTINC)) begin
                        pwr_d  = 1'b1;
                        psel_d = ptr_sel_i;
                        pval_d = (amode_i == data_space_pkg::AMODE_PREDEC) ? eff
                               : base + 16'h0001;
                    end
                end
            end
            ST_ADDR: begin
                st_d = ST_DATA;
            end
            ST_DATA: begin
                if (cnt_q == 4'h0) begin
                    st_d   = ST_IDLE;
                    rdat_d = we_q ? rdat_q : rmux;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q     <= ST_IDLE;
            addr_q   <= 16'h0000;
            loc_q    <= 16'h0000;
            reg_q    <= data_space_pkg::REGION_REGFILE;
            we_q     <= 1'b0;
            ext_on_q <= 1'b0;
            cnt_q    <= 4'h0;
            wdat_q   <= 8'h00;
            rdat_q   <= 8'h00;
            pwr_q    <= 1'b0;
            psel_q   <= data_space_pkg::PTR_X;
            pval_q   <= 16'h0000;
        end else begin
            st_q     <= st_d;
            addr_q   <= addr_d;
            loc_q    <= loc_d;
            reg_q    <= reg_d;
            we_q     <= we_d;
            ext_on_q <= ext_on_d;
            cnt_q    <= cnt_d;
            wdat_q   <= wdat_d;
            rdat_q   <= rdat_d;
            pwr_q    <= pwr_d;
            psel_q   <= psel_d;
            pval_q   <= pval_d;
        end
    end

    // ==========================================
    // outputs
    logic ext_phase;
    assign ext_phase    = (st_q == ST_DATA) && ext_on_q;
    assign ready_o      = (st_q == ST_IDLE);
    assign done_o       = (st_q == ST_DATA) && (cnt_q == 4'h0);
    assign rdata_o      = rdat_q;
    assign addr_o       = addr_q;
    assign local_addr_o = loc_q;
    assign region_o     = reg_q;
    assign addr_valid_o = (st_q != ST_IDLE);
    assign int_rd_o     = (st_q == ST_DATA) && !we_q
                        && (reg_q != data_space_pkg::REGION_EXT);
    assign int_wr_o     = (st_q == ST_DATA) && we_q
                        && (reg_q != data_space_pkg::REGION_EXT);
    assign wdata_o      = wdat_q;
    assign ext_rd_n_o   = !(ext_phase && !we_q);
    assign ext_wr_n_o   = !(ext_phase && we_q);
    assign ptr_wr_o     = pwr_q;
    assign ptr_wr_sel_o = psel_q;
    assign ptr_wr_val_o = pval_q;

    // ==========================================
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_int_no_strobe: assert property (
        (reg_q != data_space_pkg::REGION_EXT) |-> (ext_rd_n_o && ext_wr_n_o))
        else $error("strobe active on internal access");
    a_ext_off_quiet: assert property (
        (addr_valid_o && !ext_on_q) |-> (ext_rd_n_o && ext_wr_n_o))
        else $error("strobe active while external memory disabled");
    a_int_two_cycle: assert property (
        (accept && rgn != data_space_pkg::REGION_EXT) |=> addr_valid_o && !done_o ##1 done_o)
        else $error("internal access not two cycles");
    a_ext_byte_ws0: assert property (
        (accept && rgn == data_space_pkg::REGION_EXT && ext_mem_enable_bit_i
         && !pc_pair_i && wait_states_i == 2'b00) |-> !done_o [*3] ##1 done_o)
        else $error("zero-wait external byte not three cycles");
    a_ext_byte_ws3: assert property (
        (accept && rgn == data_space_pkg::REGION_EXT && ext_mem_enable_bit_i
         && !pc_pair_i && wait_states_i == 2'b11) |-> ##6 done_o && !$past(done_o))
        else $error("three-wait external byte wrong length");
    a_ext_pair_ws1: assert property (
        (accept && rgn == data_space_pkg::REGION_EXT && ext_mem_enable_bit_i
         && pc_pair_i && wait_states_i == 2'b01) |-> ##7 done_o && !$past(done_o))
        else $error("one-wait pc pair wrong length");
    a_compat_no_extio: assert property (
        (compat_mode_i && eff >= 16'h0060 && eff < 16'h1000)
        |-> rgn == data_space_pkg::REGION_SRAM)
        else $error("compat map decode wrong");
    a_port_offset: assert property (
        (accept && port_op_i) |=> addr_o == {10'h000, $past(port_addr_i)} + 16'h0020
                                  && region_o != data_space_pkg::REGION_EXTIO)
        else $error("port address offset wrong");
    a_postinc_ptr: assert property (
        (accept && !port_op_i && amode_i == data_space_pkg::AMODE_POSTINC
         && ptr_sel_i == data_space_pkg::PTR_Y)
        |=> ptr_wr_o && ptr_wr_val_o == $past(ptr_y_i) + 16'h0001 && addr_o == $past(ptr_y_i))
        else $error("post-increment wrong");
    a_normal_ext: assert property (
        (!compat_mode_i && eff >= 16'h1100) |-> rgn == data_space_pkg::REGION_EXT)
        else $error("external region decode wrong");

    c_int_read:  cover property (accept && !we_i && rgn == data_space_pkg::REGION_SRAM);
    c_ext_write: cover property (accept && we_i && rgn == data_space_pkg::REGION_EXT
                                 && ext_mem_enable_bit_i);
    c_ext_pair:  cover property (accept && pc_pair_i && ext_mem_enable_bit_i
                                 && rgn == data_space_pkg::REGION_EXT);
endmodule

// ===== bench/mem_model.sv
// memory and external sram model at the far side of the decoder
module mem_model (
    input  wire logic                    clk_sys_i,
    input  wire logic [15:0]             addr_i,
    input  wire data_space_pkg::region_t region_i,
    input  wire logic                    int_rd_i,
    input  wire logic                    ext_rd_n_i,
    output logic [7:0]                   regfile_rdata_o,
    output logic [7:0]                   stdio_rdata_o,
    output logic [7:0]                   extio_rdata_o,
    output logic [7:0]                   sram_rdata_o,
    output logic [7:0]                   ext_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // data per region, junk pattern when not read
    logic [7:0] junk_q = 8'h5A;
    logic [7:0] val;
    always_ff @(posedge clk_sys_i) junk_q <= ~junk_q + 8'h35;
    assign val = addr_i[7:0] ^ addr_i[15:8] ^ {region_i, 5'h0A};
    assign regfile_rdata_o = (int_rd_i && region_i == data_space_pkg::REGION_REGFILE)
                           ? val : junk_q;
    assign stdio_rdata_o = (int_rd_i && region_i == data_space_pkg::REGION_STDIO) ? val : junk_q;
    assign extio_rdata_o = (int_rd_i && region_i == data_space_pkg::REGION_EXTIO) ? val : junk_q;
    assign sram_rdata_o = (int_rd_i && region_i == data_space_pkg::REGION_SRAM) ? val : junk_q;
    assign ext_rdata_o = !ext_rd_n_i ? val : junk_q;
endmodule

// ===== bench/tb.sv
// self-checking bench for the data-space decoder
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // signals
    typedef struct {int acc; int lat; logic [15:0] a; data_space_pkg::region_t r;
        logic we; logic xs; logic [7:0] rd; logic [7:0] wd; logic [15:0] lo;} note_t;
    logic clk_sys_i, rst_i, compat_mode_i, ext_mem_enable_bit_i, req_i, we_i, pc_pair_i;
    logic port_op_i, ready_o, done_o, addr_valid_o, int_rd_o, int_wr_o, ptr_wr_o;
    logic ext_rd_n_o, ext_wr_n_o;
    logic [1:0] wait_states_i;
    logic [5:0] port_addr_i, disp_i;
    logic [7:0] wdata_i, regfile_rdata_i, stdio_rdata_i, extio_rdata_i, sram_rdata_i;
    logic [7:0] ext_rdata_i, rdata_o, wdata_o;
    logic [15:0] direct_addr_i, ptr_x_i, ptr_y_i, ptr_z_i, addr_o, local_addr_o;
    logic [15:0] ptr_wr_val_o;
    logic [15:0] seed = 16'hD632;
    data_space_pkg::amode_t amode_i;
    data_space_pkg::ptr_t ptr_sel_i, ptr_wr_sel_o;
    data_space_pkg::region_t region_o;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    logic pend = 1'b0;
    logic [7:0] prd;
    note_t notes[$];
    logic [15:0] bnd[11] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100,
        16'h0FFF, 16'h1000, 16'h10FF, 16'h1100, 16'hFFFF};
    // ==========================================
    // design and far side
    data_space_decoder data_space_decoder_inst (.clk_sys_i, .rst_i, .compat_mode_i,
        .ext_mem_enable_bit_i, .wait_states_i, .req_i, .we_i, .pc_pair_i, .port_op_i,
        .port_addr_i, .amode_i, .ptr_sel_i, .direct_addr_i, .disp_i, .ptr_x_i, .ptr_y_i,
        .ptr_z_i, .wdata_i, .regfile_rdata_i, .stdio_rdata_i, .extio_rdata_i, .sram_rdata_i,
        .ext_rdata_i, .ready_o, .done_o, .rdata_o, .addr_o, .local_addr_o, .region_o,
        .addr_valid_o, .int_rd_o, .int_wr_o, .wdata_o, .ext_rd_n_o, .ext_wr_n_o, .ptr_wr_o,
        .ptr_wr_sel_o, .ptr_wr_val_o);
    mem_model mem_model_inst (.clk_sys_i, .addr_i(addr_o), .region_i(region_o),
        .int_rd_i(int_rd_o), .ext_rd_n_i(ext_rd_n_o), .regfile_rdata_o(regfile_rdata_i),
        .stdio_rdata_o(stdio_rdata_i), .extio_rdata_o(extio_rdata_i),
        .sram_rdata_o(sram_rdata_i), .ext_rdata_o(ext_rdata_i));
    // ==========================================
    // helpers
    function automatic logic [15:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    function automatic data_space_pkg::region_t reg_of(logic [15:0] e, logic c);
        if (e < data_space_pkg::STDIO_BASE) return data_space_pkg::REGION_REGFILE;
        if (e < data_space_pkg::EXTIO_BASE) return data_space_pkg::REGION_STDIO;
        if (c) return e < data_space_pkg::SRAM_END_CMP ? data_space_pkg::REGION_SRAM
            : data_space_pkg::REGION_EXT;
        if (e < data_space_pkg::SRAM_BASE_NRM) return data_space_pkg::REGION_EXTIO;
        return e < data_space_pkg::SRAM_END_NRM ? data_space_pkg::REGION_SRAM
            : data_space_pkg::REGION_EXT;
    endfunction
    task automatic summarize();
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        chk(32'h0, 32'h1);
        summarize();
    endtask
    // ==========================================
    // driver
    task automatic acc_one();
        logic [15:0] r, r2, a, p, e;
        note_t n;
        int k;
        r = rnd();
        r2 = rnd();
        a = r[14] ? bnd[r2 % 11] : rnd();
        compat_mode_i = r[0];
        ext_mem_enable_bit_i = r[1];
        wait_states_i = r[3:2];
        we_i = r[4];
        pc_pair_i = r[5] & r[6];
        port_op_i = r[7] & r[8];
        amode_i = data_space_pkg::amode_t'(r[11:9] > 3'h4 ? 3'h0 : r[11:9]);
        ptr_sel_i = data_space_pkg::ptr_t'(r[13:12] == 2'h3 ? 2'h0 : r[13:12]);
        disp_i = r2[5:0];
        port_addr_i = r2[13:8];
        wdata_i = r2[15:8];
        direct_addr_i = a;
        ptr_x_i = a;
        ptr_y_i = a + 16'h0001;
        ptr_z_i = a + 16'h0002;
        p = a + 16'(ptr_sel_i);
        case (amode_i)
            data_space_pkg::AMODE_DIRECT: e = a;
            data_space_pkg::AMODE_DISP: e = p + 16'(disp_i);
            data_space_pkg::AMODE_PREDEC: e = p - 16'h0001;
            default: e = p;
        endcase
        if (port_op_i) e = 16'(port_addr_i) + 16'h0020;
        n.a = e;
        n.r = reg_of(e, compat_mode_i);
        n.we = we_i;
        n.wd = wdata_i;
        n.xs = n.r == data_space_pkg::REGION_EXT && ext_mem_enable_bit_i;
        n.lat = 2 + (n.xs ? (pc_pair_i ? 2 * wait_states_i + 3 : wait_states_i + 1) : 0);
        n.rd = (n.r == data_space_pkg::REGION_EXT && !n.xs) ? 8'h00
            : e[7:0] ^ e[15:8] ^ {n.r, 5'h0A};
        case (n.r)
            data_space_pkg::REGION_STDIO: n.lo = e - data_space_pkg::STDIO_BASE;
            data_space_pkg::REGION_EXTIO: n.lo = e - data_space_pkg::EXTIO_BASE;
            data_space_pkg::REGION_SRAM: n.lo = e - (compat_mode_i
                ? data_space_pkg::SRAM_BASE_CMP : data_space_pkg::SRAM_BASE_NRM);
            data_space_pkg::REGION_EXT: n.lo = e - (compat_mode_i
                ? data_space_pkg::SRAM_END_CMP : data_space_pkg::SRAM_END_NRM);
            default: n.lo = e;
        endcase
        for (k = 0; k < 60 && ready_o !== 1'b1; k++) @(negedge clk_sys_i);
        if (k == 60) tmo();
        req_i = 1'b1;
        n.acc = cyc;
        @(negedge clk_sys_i);
        req_i = 1'b0;
        chk({30'h0, ready_o, addr_valid_o}, 32'h1);
        k = !port_op_i && (amode_i == data_space_pkg::AMODE_PREDEC
            || amode_i == data_space_pkg::AMODE_POSTINC);
        chk(32'(ptr_wr_o), 32'(k));
        if (k != 0) chk({14'h0, ptr_wr_sel_o, ptr_wr_val_o}, {14'h0, ptr_sel_i,
            amode_i == data_space_pkg::AMODE_PREDEC ? p - 16'h0001 : p + 16'h0001});
        notes.push_back(n);
    endtask
    // ==========================================
    // monitor
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    always @(negedge clk_sys_i) begin
        note_t m;
        if (pend) chk(32'(rdata_o), 32'(prd));
        pend = 1'b0;
        if (done_o === 1'b1 && notes.size() == 0) chk(32'h1, 32'h0);
        else if (done_o === 1'b1) begin
            m = notes.pop_front();
            chk(32'(cyc - m.acc), 32'(m.lat));
            chk(32'(addr_o), 32'(m.a));
            chk(32'(region_o), 32'(m.r));
            chk(32'(local_addr_o), 32'(m.lo));
            if (!m.xs) chk({ext_rd_n_o, ext_wr_n_o}, 2'b11);
            else chk({ext_rd_n_o, ext_wr_n_o}, {m.we, !m.we});
            chk({int_rd_o, int_wr_o}, m.r == data_space_pkg::REGION_EXT ? 2'b00
                : {!m.we, m.we});
            if (m.we) chk(32'(wdata_o), 32'(m.wd));
            pend = !m.we;
            prd = m.rd;
        end
    end
    // ==========================================
    // main sequence
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        int k;
        {rst_i, compat_mode_i, ext_mem_enable_bit_i, req_i, we_i, pc_pair_i, port_op_i} = 7'h40;
        {wait_states_i, port_addr_i, disp_i, wdata_i, direct_addr_i} = 36'h0;
        {ptr_x_i, ptr_y_i, ptr_z_i} = 48'h0;
        amode_i = data_space_pkg::AMODE_DIRECT;
        ptr_sel_i = data_space_pkg::PTR_X;
        repeat (2) begin
            rst_i = 1'b1;
            repeat (20) @(negedge clk_sys_i);
            chk({ready_o, done_o, ext_rd_n_o, ext_wr_n_o, ptr_wr_o}, 5'b10110);
            rst_i = 1'b0;
            repeat (300) acc_one();
            for (k = 0; k < 60 && (notes.size() != 0 || pend); k++) @(negedge clk_sys_i);
            if (k == 60) tmo();
        end
        summarize();
    end
endmodule
